// *** logic/imu_chain.sv ***
// gyroscope sampling, factory correction and output load
// How it works
// - runs sample/process/load loop from reset, no command
// - internal clock mode default; outputs at 2000 SPS
// - per-axis converter strobe at 4100 Hz
// - loop collects latest axis data at 2000 Hz
// - three external modes let sync pin pace loop
// - out = M*raw + bias + L*accel per axis
// - coefficients held internally, never user visible
// - one control bit switches linear-g term
// - code 001 direct, 101 pulse sync, edge paces
// - data-ready pulses on every load; polarity bit
`timescale 1ns/1ps
module imu_chain
#(
  parameter int unsigned LOOP_DIV = imu_pkg::LOOP_CYCLES,
  parameter int unsigned CONV_DIV = imu_pkg::CONV_CYCLES,
  parameter logic [9*imu_pkg::CW-1:0] SCALE_M = {16'h4000, 16'h0000, 16'h0000,
                                                16'h0000, 16'h4000, 16'h0000,
                                                16'h0000, 16'h0000, 16'h4000},
  parameter logic [3*imu_pkg::CW-1:0] BIAS_V = '0,
  parameter logic [9*imu_pkg::CW-1:0] LINACC_M = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] misc_control_reg_i,
  input wire logic sync_i,
  input wire logic [3*imu_pkg::DW-1:0] gyro_raw_i,
  input wire logic [3*imu_pkg::DW-1:0] accel_cal_i,
  output logic [2:0] gyro_converter_clock_o,
  output logic [3*imu_pkg::DW-1:0] gyro_out_o,
  output logic new_sample_strobe_o
);
  import imu_pkg::*;

  // coefficients live only in parameters: no port exposes them
  logic [31:0] conv_cnt_q;
  logic [31:0] loop_cnt_q;
  logic [2:0] stb_cnt_q;
  logic sync_q;
  logic strobe_q;
  logic [3*DW-1:0] raw_q;
  logic [3*DW-1:0] out_q;
  imu_state_e state_q;

  // mode is decoded from the live control byte, so a change acts on the next tick;
  // codes other than the three sync codes keep the internal divider in charge
  wire [2:0] mode = misc_control_reg_i[MODE_LSB +: 3];
  wire linacc_en = misc_control_reg_i[LINACC_BIT];
  wire strobe_pol = misc_control_reg_i[POL_BIT];
  wire mode_ext = (mode == MODE_DIRECT) || (mode == MODE_PULSE) || (mode == MODE_SCALED);
  wire sync_rise = sync_i && !sync_q;
  wire conv_tick = (conv_cnt_q == CONV_DIV - 1);
  wire int_tick = (loop_cnt_q == LOOP_DIV - 1);
  wire loop_tick = mode_ext ? sync_rise : int_tick;

  // correction: signed fixed point, FRAC fraction bits in M and L
  logic signed [DW-1:0] corr [AXES];
  // one row of each matrix per axis, first row in the top bits
  genvar r;
  generate
    for (r = 0; r < AXES; r++) begin : g_axis
      logic signed [DW+CW+2:0] acc_m;
      logic signed [DW+CW+2:0] acc_l;
      logic signed [DW+CW+2:0] sum;
      // a signed zero keeps the whole sum signed; an unsized '0 would make the shifts logical
      localparam logic signed [DW+CW+2:0] ACC_ZERO = '0;
      // accel words are read live at the load edge; the far side holds them from tick to load
      always_comb begin
        acc_m = '0;
        acc_l = '0;
        for (int c = 0; c < AXES; c++) begin
          acc_m = acc_m + $signed(SCALE_M[(8-(3*r+c))*CW +: CW]) * $signed(raw_q[c*DW +: DW]);
          acc_l = acc_l + $signed(LINACC_M[(8-(3*r+c))*CW +: CW]) * $signed(accel_cal_i[c*DW +: DW]);
        end
        // only the linear-g term is gated; scale and bias stay
        sum = (acc_m >>> FRAC) + $signed(BIAS_V[(2-r)*CW +: CW]) + (linacc_en ? (acc_l >>> FRAC) : ACC_ZERO);
        corr[r] = sum[DW-1:0];
      end
      assign gyro_converter_clock_o[r] = conv_tick; // one converter strobe per axis
      assign gyro_out_o[r*DW +: DW] = out_q[r*DW +: DW];
    end
  endgenerate

  // both dividers run free in every mode; in the sync modes the loop divider
  // is simply not listened to, so returning to internal needs no restart
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_cnt_q <= '0;
      loop_cnt_q <= '0;
      sync_q <= 1'b0;
    end else if (clk_en_i) begin
      conv_cnt_q <= conv_tick ? '0 : conv_cnt_q + 32'h1;
      loop_cnt_q <= int_tick ? '0 : loop_cnt_q + 32'h1;
      sync_q <= sync_i;
    end
  end

  // latest converter word per axis, taken once per loop period
  // words arriving between ticks are ignored; only the one present at the tick counts
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw_q <= '0;
    end else if (clk_en_i && loop_tick && state_q == IMU_IDLE) begin
      raw_q <= gyro_raw_i;
    end
  end

  // three-step frame: IDLE waits for a tick, CALC gives the products a full
  // cycle to settle, LOAD writes the result; a tick that lands in CALC or LOAD
  // is dropped, so sync edges closer than three cycles apart lose a frame
  // rather than corrupting the one in flight
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= IMU_IDLE;
      out_q <= '0;
    end else if (clk_en_i) begin
      case (state_q)
        IMU_IDLE: begin
          if (loop_tick) begin
            state_q <= IMU_CALC;
          end
        end
        IMU_CALC: begin
          state_q <= IMU_LOAD;
        end
        IMU_LOAD: begin
          out_q <= {corr[2], corr[1], corr[0]};
          state_q <= IMU_IDLE;
        end
        default: begin
          state_q <= IMU_IDLE;
        end
      endcase
    end
  end

  // strobe active for STROBE_CYCLES after each load
  // a load inside a running strobe restarts the count, so the pulse stretches
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stb_cnt_q <= '0;
      strobe_q <= 1'b0;
    end else if (clk_en_i) begin
      if (state_q == IMU_LOAD) begin
        stb_cnt_q <= 3'(STROBE_CYCLES);
        strobe_q <= 1'b1;
      end else if (stb_cnt_q != 3'h0) begin
        stb_cnt_q <= stb_cnt_q - 3'h1;
        strobe_q <= (stb_cnt_q != 3'h1);
      end
    end
  end
  // polarity bit high: strobe active high, idle low
  assign new_sample_strobe_o = strobe_pol ? strobe_q : !strobe_q;

  // reference dividers for the checks below, kept apart from the design counters
  // so that a broken wrap or tick decode shows as a mismatch rather than agreeing
  // with itself; they freeze with the clock enable like the design does
  logic [31:0] chk_conv_gap_q;
  logic [31:0] chk_loop_gap_q;
  wire chk_conv_end = (chk_conv_gap_q == CONV_DIV - 1);
  wire chk_loop_end = (chk_loop_gap_q == LOOP_DIV - 1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chk_conv_gap_q <= '0;
      chk_loop_gap_q <= '0;
    end else if (clk_en_i) begin
      chk_conv_gap_q <= chk_conv_end ? 32'h0 : chk_conv_gap_q + 32'h1;
      chk_loop_gap_q <= chk_loop_end ? 32'h0 : chk_loop_gap_q + 32'h1;
    end
  end

  // with clock enable low every state holds, so moves are only expected on enabled edges
  a_load_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q == IMU_LOAD) |=> strobe_q)
    else $error("strobe missing after load");
  a_tick_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q == IMU_IDLE && loop_tick) |=> (state_q == IMU_CALC))
    else $error("loop tick did not start processing");
  a_internal_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && !mode_ext && state_q == IMU_IDLE) |=> (state_q == ($past(chk_loop_end) ? IMU_CALC : IMU_IDLE)))
    else $error("internal loop rate wrong");
  a_ext_pace: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && mode_ext && state_q == IMU_IDLE)
    |=> (state_q == ($past(sync_i && !sync_q) ? IMU_CALC : IMU_IDLE)))
    else $error("external mode ticked without sync edge");
  a_sync_edge: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && (mode == MODE_DIRECT || mode == MODE_PULSE) && sync_rise && state_q == IMU_IDLE)
    |=> ##1 (state_q == IMU_LOAD))
    else $error("sync edge did not lead to load");
  a_conv_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    gyro_converter_clock_o == {3{chk_conv_end}})
    else $error("converter strobe wrong");
  a_load_value: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q == IMU_LOAD) |=> (out_q == $past({corr[2], corr[1], corr[0]})))
    else $error("output not loaded with correction");
  a_raw_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q == IMU_IDLE && loop_tick) |=> (raw_q == $past(gyro_raw_i)))
    else $error("raw sample not captured");
  a_strobe_len: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q == IMU_LOAD) |=> strobe_q[*4])
    else $error("strobe too short");
  a_out_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_q != IMU_LOAD) |=> $stable(out_q))
    else $error("output changed outside a load");
  a_busy_refuse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_q != IMU_IDLE) |=> $stable(raw_q))
    else $error("raw sample taken while busy");
  a_calc_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q == IMU_CALC) |=> (state_q == IMU_LOAD))
    else $error("processing stalled before load");
  a_strobe_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_q != IMU_LOAD && stb_cnt_q == 3'h1) |=> !strobe_q)
    else $error("strobe outlasted its count");
  // covers: one frame in each pacing mode and one without the linear-g term
  c_internal: cover property (@(posedge clk_i) disable iff (!reset_n_i) !mode_ext && state_q == IMU_LOAD);
  c_direct: cover property (@(posedge clk_i) disable iff (!reset_n_i) mode == MODE_DIRECT && state_q == IMU_LOAD);
  c_pulse: cover property (@(posedge clk_i) disable iff (!reset_n_i) mode == MODE_PULSE && state_q == IMU_LOAD);
  c_nolin: cover property (@(posedge clk_i) disable iff (!reset_n_i) !linacc_en && state_q == IMU_LOAD);
  c_scaled: cover property (@(posedge clk_i) disable iff (!reset_n_i) mode == MODE_SCALED && state_q == IMU_LOAD);
endmodule : imu_chain

// *** logic/imu_pkg.sv ***
// constants for the gyroscope sample and calibration chain
package imu_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CONV_RATE_HZ = 4100;
  localparam int unsigned LOOP_RATE_HZ = 2000;
  localparam int unsigned CONV_CYCLES = CLK_HZ / CONV_RATE_HZ;
  localparam int unsigned LOOP_CYCLES = CLK_HZ / LOOP_RATE_HZ;
  localparam int unsigned STROBE_CYCLES = 4;
  localparam int DW = 16;
  localparam int CW = 16;
  localparam int FRAC = 14;
  localparam int AXES = 3;
  // clock-mode field and control bit positions
  localparam int MODE_LSB = 2;
  localparam int LINACC_BIT = 7;
  localparam int POL_BIT = 0;
  localparam logic [2:0] MODE_INTERNAL = 3'h0;
  localparam logic [2:0] MODE_DIRECT = 3'h1;
  localparam logic [2:0] MODE_PULSE = 3'h5;
  localparam logic [2:0] MODE_SCALED = 3'h2;
  localparam logic [7:0] MISC_CTRL_RESET = 8'h81;
  typedef enum logic [1:0] {
    IMU_IDLE = 2'b00,
    IMU_CALC = 2'b01,
    IMU_LOAD = 2'b10
  } imu_state_e;
endpackage : imu_pkg

// *** tb/imu_sensor_model.sv ***
// far-side model: sensing elements plus external sync source
`timescale 1ns/1ps
module imu_sensor_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [47:0] raw_set_i,
  input wire logic [47:0] acc_set_i,
  input wire logic sync_req_i,
  output logic [47:0] gyro_raw_o,
  output logic [47:0] accel_cal_o,
  output logic sync_o
);
  logic [1:0] width_q = 2'h0;
  // start from a quiet sensor so the first frame after reset is known
  initial begin
    gyro_raw_o = '0;
    accel_cal_o = '0;
  end
  // samples move only on request, so a capture never sees a half-new vector
  always @(posedge clk_i) begin
    if (load_i) begin
      gyro_raw_o <= raw_set_i;
      accel_cal_o <= acc_set_i;
    end
    width_q <= sync_req_i ? 2'h3 : width_q - 2'(width_q != 2'h0);
  end
  assign sync_o = (width_q != 2'h0);
endmodule : imu_sensor_model

// *** tb/test_imu_sample_and_calibration_chain.sv ***
// self-checking bench for the gyro sample and correction chain
`timescale 1ns/1ps
module test_imu_sample_and_calibration_chain;
  import imu_pkg::*;
  localparam int LD = 50;
  localparam int CD = 20;
  localparam logic [143:0] SM = {16'h4000, 16'h2000, 16'h0, 16'h0, 16'h4000, 16'h0, 16'h0, 16'hE000, 16'h4000};
  localparam logic [47:0] BV = {16'h0010, 16'hFFF0, 16'h0100};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic load = 1'b0;
  logic sync_req = 1'b0;
  logic sync, strobe;
  logic [7:0] misc = MISC_CTRL_RESET;
  logic [47:0] raw_set = '0, acc_set = '0, raw, acc, gyro_out;
  logic [2:0] conv;
  logic [7:0] codes [6] = '{8'h81, 8'h01, 8'h80, 8'h85, 8'h95, 8'h89};
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 clk_i = ~clk_i;
  imu_chain #(.LOOP_DIV(LD), .CONV_DIV(CD), .SCALE_M(SM), .BIAS_V(BV), .LINACC_M(SM)) u_dut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .clk_en_i(1'b1), .misc_control_reg_i(misc), .sync_i(sync), .gyro_raw_i(raw),
    .accel_cal_i(acc), .gyro_converter_clock_o(conv), .gyro_out_o(gyro_out), .new_sample_strobe_o(strobe));
  imu_sensor_model u_far (.clk_i(clk_i), .load_i(load), .raw_set_i(raw_set), .acc_set_i(acc_set),
    .sync_req_i(sync_req), .gyro_raw_o(raw), .accel_cal_o(acc), .sync_o(sync));
  function automatic logic [47:0] expect_out(logic [47:0] r, logic [47:0] a, logic en);
    logic signed [47:0] s, t;
    logic [47:0] o;
    for (int i = 0; i < 3; i++) begin
      s = 0;
      t = 0;
      for (int j = 0; j < 3; j++) begin
        s += $signed(SM[(8-3*i-j)*16 +: 16]) * $signed(r[j*16 +: 16]);
        t += $signed(SM[(8-3*i-j)*16 +: 16]) * $signed(a[j*16 +: 16]);
      end
      o[i*16 +: 16] = 16'((s >>> 14) + $signed(BV[(2-i)*16 +: 16]) + (en ? (t >>> 14) : 48'sh0));
    end
    return o;
  endfunction : expect_out
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : step
  task automatic check(logic [47:0] got, logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // counts cycles up to the next active onset; 400 means none came
  task automatic wait_strobe(output int n);
    n = 0;
    while (strobe === misc[0] && n < 400) begin
      step(1);
      n++;
    end
    while (strobe !== misc[0] && n < 400) begin
      step(1);
      n++;
    end
  endtask : wait_strobe
  task automatic run(logic [7:0] c);
    int n;
    logic ext;
    ext = (c[4:2] == MODE_DIRECT) || (c[4:2] == MODE_PULSE) || (c[4:2] == MODE_SCALED);
    misc = c;
    for (int k = 0; k < 4; k++) begin
      raw_set = k == 0 ? 48'h8000_7FFF_FFFF : 48'({$urandom, $urandom});
      acc_set = k == 0 ? 48'h7FFF_8000_0001 : 48'({$urandom, $urandom});
      load = 1'b1;
      sync_req = 1'b1;
      step(1);
      load = 1'b0;
      sync_req = 1'b0;
      wait_strobe(n);
      if (k > 0 || ext) check(48'(n), ext ? 48'h3 : 48'(LD - 6));
      check(gyro_out, expect_out(raw_set, acc_set, c[7]));
      step(5);
    end
    $display("test ctrl=%h done", c);
  endtask : run
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    int n;
    void'($urandom(32'hB186));
    step(12);
    reset_n_i = 1'b1;
    wait_strobe(n);
    check(48'(n), 48'(LD + 2));
    check(gyro_out, expect_out('0, '0, 1'b1));
    $display("test reset start done");
    n = 0;
    do begin
      step(1);
      n++;
    end while (conv !== 3'h7 && n < 100);
    n = 0;
    do begin
      step(1);
      n++;
    end while (conv !== 3'h7 && n < 100);
    check(48'(n), 48'(CD));
    $display("test converter done");
    wait_strobe(n);
    step(5);
    foreach (codes[i]) run(codes[i]);
    wait_strobe(n);
    check(48'(n), 48'h190);
    $display("test no sync done");
    end_of_test();
  end
endmodule : test_imu_sample_and_calibration_chain
